// ---- wbarb_top.sv ----
// Writeback slot arbiter, scoreboard, feed forward and issue timing.
// Assumes one processor clock; memory replies are synchronous to it.
//
// Functional notes
// - Priority IU, int multiply, fmul, add pipe, loads.
// - Only top requester gets the slot.
// - Refused FPU unit repeats final stage.
// - Loads park in primary then secondary latch.
// - No new data access when latches stuck.
// - Refused unit stalls its pipeline.
// - Destination reserved until written back.
// - Forward result bus to waiting source.
// - Wait replies hold next address phase.
// - Register hold repeats next address phase.
// - Integer ops one clock, listed checks.
// - Branch timing two taken, one otherwise.
// - Trap taken three, not taken one.
// - Calls check and reserve register one.
// - Add pipe five or six, plus divides.
// - Multiply six, seven, nine; integer four.
// - Double result extra final clock sometimes.
// - Load writes back after three clocks.
`timescale 1ns/100ps
`include "wbarb_params.svh"
module wbarb_top (
   input  wire logic                   clock,
   input  wire logic                   nrst,
   input  wire wbarb_pkg::wba_issue_s  issue,
   input  wire wbarb_pkg::wba_wb_s     iu_wb,
   input  wire wbarb_pkg::wba_wb_s     ld_wb,
   input  wire logic                   ld_req,
   input  wire logic                   fetch_wait,
   input  wire logic                   data_wait,
   input  wire logic [31:0]            fpu_add_res,
   input  wire logic [31:0]            fpu_mul_res,
   output logic                        issue_ack_r,
   output logic                        addr_hold_r,
   output logic                        data_start_r,
   output logic [4:0]                  grant_r,
   output wbarb_pkg::wba_wb_s          rbus_r,
   output logic [31:0]                 sb_r,
   output logic                        fwd_rs1_r,
   output logic                        fwd_rs2_r,
   output logic                        fadd_stall_r,
   output logic                        fmul_stall_r,
   output logic [2:0]                  iu_busy_r
);
   //--------------------------------------------------------------
   // Decode helpers
   //--------------------------------------------------------------
   // Register bit decode used by scoreboard check and set
   function automatic logic [31:0] reg_bit(input logic [4:0] r);
      reg_bit = 32'h1 << r;
   endfunction
   // FPU latency from op and operand widths
   function automatic logic [6:0] fpu_lat(input wbarb_pkg::wba_issue_s i);
      logic [6:0] base;
      base = (i.s1_dbl || i.s2_dbl) ? `WBA_ADD_DBL : `WBA_ADD_SGL;
      fpu_lat = base;
      unique case (i.op)
         wbarb_pkg::WBA_OP_FDIV: fpu_lat = base +
            (i.rd[0] ? `WBA_DIV_DBL_ITER : `WBA_DIV_SGL_ITER);
         wbarb_pkg::WBA_OP_IDIV: fpu_lat = `WBA_ADD_SGL + `WBA_DIV_INT_ITER;
         wbarb_pkg::WBA_OP_FMUL: fpu_lat = (i.s1_dbl && i.s2_dbl) ? `WBA_MUL_TWO_DBL :
            ((i.s1_dbl || i.s2_dbl) ? `WBA_MUL_ONE_DBL : `WBA_MUL_SGL);
         wbarb_pkg::WBA_OP_IMUL: fpu_lat = `WBA_MUL_INT;
         default: fpu_lat = base;
      endcase
      if (i.dbl_use) begin
         fpu_lat = fpu_lat + 7'h01;
      end
   endfunction
   //--------------------------------------------------------------
   // FPU unit countdowns and final stage hold
   //--------------------------------------------------------------
   logic [6:0] add_cnt_r, mul_cnt_r;
   logic [4:0] add_rd_r, mul_rd_r;
   logic       mul_int_r;
   logic [4:0] req;
   logic [4:0] gnt;
   logic       add_done, mul_done, issue_go;
   wbarb_pkg::wba_wb_s lat_head;
   logic       lat_full;
   assign add_done = add_cnt_r == 7'h01;
   assign mul_done = mul_cnt_r == 7'h01;
   // Requests indexed by rank, zero highest
   always_comb begin
      req = '0;
      req[`WBA_SRC_IU]   = iu_wb.valid;
      req[`WBA_SRC_IMUL] = mul_done && mul_int_r;
      req[`WBA_SRC_FMUL] = mul_done && !mul_int_r;
      req[`WBA_SRC_FADD] = add_done;
      req[`WBA_SRC_LD]   = lat_head.valid;
   end
   // Fixed priority pick: lowest index wins, one grant per clock
   always_comb begin
      gnt = '0;
      for (int k = `WBA_NUM_SRC - 1; k >= 0; k--) begin
         if (req[k]) begin
            gnt = 5'h00;
            gnt[k] = 1'b1;
         end
      end
   end
   // Countdown stops at one: the final stage repeats until granted
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         add_cnt_r <= 7'h00;
         add_rd_r  <= 5'h00;
      end else if (add_done && !gnt[`WBA_SRC_FADD]) begin
         add_cnt_r <= add_cnt_r;
      end else if (issue_go && (issue.op == wbarb_pkg::WBA_OP_FADD ||
                   issue.op == wbarb_pkg::WBA_OP_FDIV ||
                   issue.op == wbarb_pkg::WBA_OP_IDIV)) begin
         add_cnt_r <= fpu_lat(issue);
         add_rd_r  <= issue.rd;
      end else if (add_cnt_r != 7'h00) begin
         add_cnt_r <= add_cnt_r - 7'h01;
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mul_cnt_r <= 7'h00;
         mul_rd_r  <= 5'h00;
         mul_int_r <= 1'b0;
      end else if (mul_done && !(gnt[`WBA_SRC_FMUL] || gnt[`WBA_SRC_IMUL])) begin
         mul_cnt_r <= mul_cnt_r;
      end else if (issue_go && (issue.op == wbarb_pkg::WBA_OP_FMUL ||
                   issue.op == wbarb_pkg::WBA_OP_IMUL)) begin
         mul_cnt_r <= fpu_lat(issue);
         mul_rd_r  <= issue.rd;
         mul_int_r <= issue.op == wbarb_pkg::WBA_OP_IMUL;
      end else if (mul_cnt_r != 7'h00) begin
         mul_cnt_r <= mul_cnt_r - 7'h01;
      end
   end
   //--------------------------------------------------------------
   // Load path: pipeline delay then holding latches
   //--------------------------------------------------------------
   wbarb_pkg::wba_wb_s ld_pipe_r [`WBA_LD_LATENCY-1];
   wbarb_pkg::wba_ld_e ld_st_r;
   // Two stages here plus the latch make the three clock latency
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ld_pipe_r[0] <= '0;
         ld_pipe_r[1] <= '0;
      end else begin
         ld_pipe_r[0] <= ld_wb;
         ld_pipe_r[1] <= ld_pipe_r[0];
      end
   end
   wbarb_latch u_latch (
      .clock  (clock),
      .nrst   (nrst),
      .in_wb  (ld_pipe_r[1]),
      .pop    (gnt[`WBA_SRC_LD]),
      .head_r (lat_head),
      .full_r (lat_full)
   );
   // Outstanding access tracker for the latch overflow guard
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ld_st_r <= wbarb_pkg::WBA_LD_IDLE;
      end else begin
         unique case (ld_st_r)
            wbarb_pkg::WBA_LD_IDLE:
               ld_st_r <= lat_head.valid ? wbarb_pkg::WBA_LD_ONE : wbarb_pkg::WBA_LD_IDLE;
            wbarb_pkg::WBA_LD_ONE:
               ld_st_r <= !lat_head.valid ? wbarb_pkg::WBA_LD_IDLE :
                          (lat_full ? wbarb_pkg::WBA_LD_TWO : wbarb_pkg::WBA_LD_ONE);
            wbarb_pkg::WBA_LD_TWO:
               ld_st_r <= lat_full ? wbarb_pkg::WBA_LD_TWO : wbarb_pkg::WBA_LD_ONE;
         endcase
      end
   end
   // Data starts blocked while both latches are tied up
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         data_start_r <= 1'b0;
      end else begin
         data_start_r <= ld_req && !data_wait && !lat_full &&
                         ld_st_r != wbarb_pkg::WBA_LD_TWO;
      end
   end
   //--------------------------------------------------------------
   // Result bus and scoreboard
   //--------------------------------------------------------------
   wbarb_pkg::wba_wb_s rbus_nxt;
   logic [31:0] chk, set_bits;
   // Only one source reaches the bus each clock
   always_comb begin
      rbus_nxt = '0;
      unique case (1'b1)
         gnt[`WBA_SRC_IU]:   rbus_nxt = iu_wb;
         gnt[`WBA_SRC_IMUL], gnt[`WBA_SRC_FMUL]: rbus_nxt = '{1'b1, mul_rd_r, fpu_mul_res};
         gnt[`WBA_SRC_FADD]: rbus_nxt = '{1'b1, add_rd_r, fpu_add_res};
         gnt[`WBA_SRC_LD]:   rbus_nxt = lat_head;
         default:            rbus_nxt = '0;
      endcase
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rbus_r  <= '0;
         grant_r <= 5'h00;
      end else begin
         rbus_r  <= rbus_nxt;
         grant_r <= gnt;
      end
   end
   // Checked registers; calls use register one as destination
   always_comb begin
      chk = '0;
      if (issue.use_rs1 && issue.op != wbarb_pkg::WBA_OP_RDCR)
         chk = chk | reg_bit(issue.rs1);
      if (issue.use_rs2 && !(issue.op inside {wbarb_pkg::WBA_OP_FF1, wbarb_pkg::WBA_OP_RDCR,
          wbarb_pkg::WBA_OP_WRCR, wbarb_pkg::WBA_OP_XCR, wbarb_pkg::WBA_OP_BCOND,
          wbarb_pkg::WBA_OP_TRAP}))
         chk = chk | reg_bit(issue.rs2);
      if (issue.use_rd && issue.op != wbarb_pkg::WBA_OP_WRCR)
         chk = chk | reg_bit(issue.rd);
      if (issue.op == wbarb_pkg::WBA_OP_CALL) chk = chk | reg_bit(`WBA_LINK_REG);
      if (rbus_nxt.valid) chk = chk & ~reg_bit(rbus_nxt.dest);
   end
   assign issue_go = issue.valid && ((chk & sb_r) == 32'h0) && iu_busy_r == 3'h0;
   always_comb begin
      set_bits = '0;
      if (issue_go) begin
         if (issue.op == wbarb_pkg::WBA_OP_CALL) set_bits = reg_bit(`WBA_LINK_REG);
         else if (issue.use_rd && issue.op != wbarb_pkg::WBA_OP_WRCR)
            set_bits = reg_bit(issue.rd);
      end
   end
   // Set wins over a clear of the same register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sb_r <= 32'h0;
      end else begin
         sb_r <= (sb_r & ~(rbus_nxt.valid ? reg_bit(rbus_nxt.dest) : 32'h0))
                 | set_bits;
      end
   end
   // Forward selects when the writeback register is a source
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         fwd_rs1_r <= 1'b0;
         fwd_rs2_r <= 1'b0;
      end else begin
         fwd_rs1_r <= issue_go && rbus_nxt.valid && issue.use_rs1 &&
                      issue.rs1 == rbus_nxt.dest;
         fwd_rs2_r <= issue_go && rbus_nxt.valid && issue.use_rs2 &&
                      issue.rs2 == rbus_nxt.dest;
      end
   end
   //--------------------------------------------------------------
   // Issue timing, stalls and address phase hold
   //--------------------------------------------------------------
   logic [2:0] clks;
   // Cycle cost of instruction unit operations
   always_comb begin
      clks = `WBA_IU_CLKS;
      unique case (issue.op)
         wbarb_pkg::WBA_OP_BCOND: clks = issue.taken ? `WBA_BR_TAKEN : `WBA_IU_CLKS;
         wbarb_pkg::WBA_OP_JMP, wbarb_pkg::WBA_OP_CALL: clks = `WBA_BR_TAKEN;
         wbarb_pkg::WBA_OP_TRAP: clks = issue.taken ? `WBA_TRAP_TAKEN : `WBA_IU_CLKS;
         wbarb_pkg::WBA_OP_RTE: clks = `WBA_RTE_CLKS;
         default: clks = `WBA_IU_CLKS;
      endcase
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         iu_busy_r <= 3'h0;
      end else if (iu_busy_r != 3'h0) begin
         iu_busy_r <= iu_busy_r - 3'h1;
      end else if (issue_go) begin
         iu_busy_r <= clks - 3'h1;
      end
   end
   // Refused units stall until written back
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         fadd_stall_r <= 1'b0;
         fmul_stall_r <= 1'b0;
      end else begin
         fadd_stall_r <= req[`WBA_SRC_FADD] && !gnt[`WBA_SRC_FADD];
         fmul_stall_r <= (req[`WBA_SRC_FMUL] || req[`WBA_SRC_IMUL]) &&
                         !(gnt[`WBA_SRC_FMUL] || gnt[`WBA_SRC_IMUL]);
      end
   end
   // Waits can repeat for any length; hold simply persists
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         addr_hold_r <= 1'b0;
         issue_ack_r <= 1'b0;
      end else begin
         addr_hold_r <= fetch_wait || data_wait ||
                        (issue.valid && !issue_go);
         issue_ack_r <= issue_go;
      end
   end
   //--------------------------------------------------------------
   // Assertions
   //--------------------------------------------------------------
   property p_onehot;
      @(posedge clock) disable iff (!nrst) $onehot0(grant_r);
   endproperty
   a_onehot: assert property (p_onehot) else $error("two grants");
   property p_iu_first;
      @(posedge clock) disable iff (!nrst) iu_wb.valid |=> grant_r[`WBA_SRC_IU];
   endproperty
   a_iu_first: assert property (p_iu_first) else $error("iu not first");
   property p_ld_last;
      @(posedge clock) disable iff (!nrst)
         (req[`WBA_SRC_LD] && req[`WBA_SRC_FADD]) |=> !grant_r[`WBA_SRC_LD];
   endproperty
   a_ld_last: assert property (p_ld_last) else $error("load beat fpu");
   property p_fpu_hold;
      @(posedge clock) disable iff (!nrst)
         (add_done && !gnt[`WBA_SRC_FADD]) |=> add_done;
   endproperty
   a_fpu_hold: assert property (p_fpu_hold) else $error("fpu lost");
   property p_stall;
      @(posedge clock) disable iff (!nrst)
         (add_done && !gnt[`WBA_SRC_FADD]) |=> fadd_stall_r;
   endproperty
   a_stall: assert property (p_stall) else $error("no stall");
   property p_no_start;
      @(posedge clock) disable iff (!nrst) lat_full |=> !data_start_r;
   endproperty
   a_no_start: assert property (p_no_start) else $error("overflow risk");
   property p_wait_hold;
      @(posedge clock) disable iff (!nrst) fetch_wait |=> addr_hold_r;
   endproperty
   a_wait_hold: assert property (p_wait_hold) else $error("no hold");
   property p_sb_set;
      @(posedge clock) disable iff (!nrst)
         (issue_go && issue.op == wbarb_pkg::WBA_OP_CALL) |=> sb_r[`WBA_LINK_REG];
   endproperty
   a_sb_set: assert property (p_sb_set) else $error("link not reserved");
   property p_branch;
      @(posedge clock) disable iff (!nrst)
         (issue_go && issue.op == wbarb_pkg::WBA_OP_BCOND && issue.taken)
         |=> iu_busy_r == 3'h1;
   endproperty
   a_branch: assert property (p_branch) else $error("branch cost");
   property p_ld_lat;
      @(posedge clock) disable iff (!nrst)
         (ld_wb.valid && !lat_head.valid) |-> ##3 lat_head.valid;
   endproperty
   a_ld_lat: assert property (p_ld_lat) else $error("load latency");
   c_fwd:   cover property (@(posedge clock) fwd_rs1_r);
   c_full:  cover property (@(posedge clock) lat_full);
   c_fstal: cover property (@(posedge clock) fadd_stall_r ##1 grant_r[`WBA_SRC_FADD]);
endmodule

// ---- wbarb_params.svh ----
// Constants for the writeback arbiter and issue timing block.
// Assumes inclusion by the package and the design files only.
`ifndef WBARB_PARAMS_SVH
`define WBARB_PARAMS_SVH
`define WBA_NUM_SRC       5
`define WBA_REGS          32
`define WBA_LINK_REG      5'h01
`define WBA_LD_LATENCY    3
`define WBA_IU_CLKS       3'h1
`define WBA_BR_TAKEN      3'h2
`define WBA_TRAP_TAKEN    3'h3
`define WBA_RTE_CLKS      3'h3
`define WBA_ADD_SGL       7'h05
`define WBA_ADD_DBL       7'h06
`define WBA_DIV_SGL_ITER  7'h19
`define WBA_DIV_DBL_ITER  7'h36
`define WBA_DIV_INT_ITER  7'h21
`define WBA_MUL_SGL       7'h06
`define WBA_MUL_ONE_DBL   7'h07
`define WBA_MUL_TWO_DBL   7'h09
`define WBA_MUL_INT       7'h04
`define WBA_SRC_IU        0
`define WBA_SRC_IMUL      1
`define WBA_SRC_FMUL      2
`define WBA_SRC_FADD      3
`define WBA_SRC_LD        4
`endif

// ---- wbarb_pkg.sv ----
// Types shared by the writeback arbiter and its holding latch.
// Assumes wbarb_params.svh is on the include path.
`include "wbarb_params.svh"
package wbarb_pkg;
   // One writeback request: destination and value
   typedef struct packed {
      logic        valid;
      logic [4:0]  dest;
      logic [31:0] data;
   } wba_wb_s;
   // Issue description from decode
   typedef struct packed {
      logic        valid;
      logic [3:0]  op;
      logic        use_rs1;
      logic        use_rs2;
      logic        use_rd;
      logic [4:0]  rs1;
      logic [4:0]  rs2;
      logic [4:0]  rd;
      logic        taken;
      logic        s1_dbl;
      logic        s2_dbl;
      logic        dbl_use;
   } wba_issue_s;
   typedef enum logic [3:0] {
      WBA_OP_IU, WBA_OP_FF1, WBA_OP_RDCR, WBA_OP_WRCR, WBA_OP_XCR, WBA_OP_BCOND,
      WBA_OP_JMP, WBA_OP_CALL, WBA_OP_TRAP, WBA_OP_RTE, WBA_OP_FADD, WBA_OP_FDIV,
      WBA_OP_IDIV, WBA_OP_FMUL, WBA_OP_IMUL, WBA_OP_DELAYED
   } wba_op_e;
   typedef enum logic [1:0] {WBA_LD_IDLE, WBA_LD_ONE, WBA_LD_TWO} wba_ld_e;
endpackage

// ---- wbarb_latch.sv ----
// Two-entry load holding latch: primary and secondary writeback latch.
// Assumes the producer never overfills it.
`timescale 1ns/100ps
`include "wbarb_params.svh"
module wbarb_latch (
   input  wire logic              clock,
   input  wire logic              nrst,
   input  wire wbarb_pkg::wba_wb_s in_wb,
   input  wire logic              pop,
   output wbarb_pkg::wba_wb_s     head_r,
   output logic                   full_r
);
   wbarb_pkg::wba_wb_s second_r;
   // Secondary shifts forward when primary frees
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         head_r   <= '0;
         second_r <= '0;
      end else begin
         if (!head_r.valid || pop) begin
            if (second_r.valid) begin
               head_r   <= second_r;
               second_r <= in_wb;
            end else begin
               head_r   <= in_wb;
               second_r <= '0;
            end
         end else if (in_wb.valid) begin
            second_r <= in_wb;
         end
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         full_r <= 1'b0;
      end else begin
         full_r <= head_r.valid && second_r.valid && !pop;
      end
   end
endmodule

// ---- wbarb_mem_model.sv ----
// Data-side memory party: takes one access, then answers after a set
// count of wait replies. Assumes the processor clock and its reset.
`timescale 1ns/100ps
module wbarb_mem_model (
   input  wire logic          clock,
   input  wire logic          nrst,
   input  wire logic          ld_req,
   input  wire logic          data_start_r,
   input  wire logic [3:0]    waits,
   input  wire logic [4:0]    dest,
   input  wire logic [31:0]   data,
   output logic               data_wait,
   output wbarb_pkg::wba_wb_s ld_wb
);
   logic        busy_r;
   logic [3:0]  cnt_r;
   logic [4:0]  dest_r;
   logic [31:0] data_r;
   // One access at a time; idle lines flip
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         busy_r    <= 1'b0;
         cnt_r     <= 4'h0;
         dest_r    <= 5'h00;
         data_r    <= 32'h0;
         data_wait <= 1'b0;
         ld_wb     <= '0;
      end else begin
         ld_wb     <= {1'b0, ~ld_wb.dest, ~ld_wb.data};
         data_wait <= 1'b0;
         if (!busy_r && ld_req && data_start_r) begin
            busy_r <= 1'b1;
            cnt_r  <= waits;
            dest_r <= dest;
            data_r <= data;
         end else if (busy_r && cnt_r != 4'h0) begin
            data_wait <= 1'b1;
            cnt_r     <= cnt_r - 4'h1;
         end else if (busy_r) begin
            busy_r <= 1'b0;
            ld_wb  <= {1'b1, dest_r, data_r};  // Success reply with the word
         end
      end
   end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the writeback arbiter.
// Assumes the design files and the memory model are compiled first.
`timescale 1ns/100ps
module testbench;
   localparam int B = 300;  // Bound on every wait
   logic                  clock = 1'b0;
   logic                  nrst = 1'b0;
   wbarb_pkg::wba_issue_s issue = '0;
   wbarb_pkg::wba_wb_s    iu_wb = '0;
   wbarb_pkg::wba_wb_s    ld_wb, rbus;
   logic                  ld_req = 1'b0;
   logic                  fetch_wait = 1'b0;
   logic [31:0]           fpu_add_res = 32'h0;
   logic [31:0]           fpu_mul_res = 32'h0;
   logic [3:0]            waits = 4'h0;
   logic [4:0]            ld_dest = 5'h00;
   logic [31:0]           ld_data = 32'h0;
   logic                  data_wait, ack, hold, dstart, frs1, frs2, fas, fms;
   logic [4:0]            grant;
   logic [31:0]           sb;
   logic [2:0]            busy;
   int                    mismatches = 0;
   int                    check_count = 0;
   always #2.5 clock = ~clock;
   wbarb_top wbarb_top_inst (.clock(clock), .nrst(nrst), .issue(issue), .iu_wb(iu_wb),
      .ld_wb(ld_wb), .ld_req(ld_req), .fetch_wait(fetch_wait), .data_wait(data_wait),
      .fpu_add_res(fpu_add_res), .fpu_mul_res(fpu_mul_res), .issue_ack_r(ack),
      .addr_hold_r(hold), .data_start_r(dstart), .grant_r(grant), .rbus_r(rbus),
      .sb_r(sb), .fwd_rs1_r(frs1), .fwd_rs2_r(frs2), .fadd_stall_r(fas),
      .fmul_stall_r(fms), .iu_busy_r(busy));
   wbarb_mem_model wbarb_mem_model_inst (.clock(clock), .nrst(nrst), .ld_req(ld_req),
      .data_start_r(dstart), .waits(waits), .dest(ld_dest), .data(ld_data),
      .data_wait(data_wait), .ld_wb(ld_wb));
   // ----------------------------------------
   // Helpers and expectations
   // ----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic check(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("Error at %0t ns: %s", $time, msg);
      end
   endtask
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Edges until accept (-1), a grant bit (0..4), load reply (5) or data start (6)
   task automatic wait_on(input int sel, output int n);
      n = 0;
      do begin
         tick(1);
         n++;
         if (n > B) begin
            check(1'b0, "wait bound ran out");
            test_done();
         end
      end while (((sel < 0) ? ack : (sel == 5) ? ld_wb.valid : (sel == 6) ? dstart :
                  grant[sel]) !== 1'b1);
   endtask
   task automatic load(input logic [3:0] w);
      int n;
      waits = w;
      ld_dest = 5'h02 + 5'($urandom_range(0, 29));
      ld_data = $urandom();
      ld_req = 1'b1;
      wait_on(6, n);
      tick(1);
      ld_req = 1'b0;
   endtask
   function automatic wbarb_pkg::wba_issue_s mk(input logic [3:0] op,
      input logic [4:0] s1, input logic [4:0] s2, input logic [4:0] d, input logic u,
      input logic tk);
      mk = '0;
      mk.valid = 1'b1;
      mk.op = op;
      mk.rs1 = s1;
      mk.rs2 = s2;
      mk.rd = d;
      mk.use_rs1 = u;
      mk.use_rs2 = u;
      mk.use_rd = u && d != 5'h00;
      mk.taken = tk;
   endfunction
   function automatic int exp_clks(input logic [3:0] op, input logic tk);
      case (op)
         wbarb_pkg::WBA_OP_BCOND: return tk ? 2 : 1;
         wbarb_pkg::WBA_OP_JMP:   return 2;
         wbarb_pkg::WBA_OP_TRAP:  return tk ? 3 : 1;
         wbarb_pkg::WBA_OP_RTE:   return 3;
         default:                 return 1;
      endcase
   endfunction
   function automatic int exp_lat(input logic [3:0] op, input logic d1,
      input logic d2, input logic r0, input logic u);
      case (op)
         wbarb_pkg::WBA_OP_FADD: return ((d1 | d2) ? 6 : 5) + int'(u);
         wbarb_pkg::WBA_OP_FDIV: return r0 ? 59 : 30;
         wbarb_pkg::WBA_OP_IDIV: return 38;
         wbarb_pkg::WBA_OP_FMUL: return 6 + int'(d1) + 2 * int'(d1 & d2);
         default:                return 4;
      endcase
   endfunction
   function automatic int gbit(input logic [3:0] op);
      return (op == wbarb_pkg::WBA_OP_FMUL) ? 2 : (op == wbarb_pkg::WBA_OP_IMUL) ? 1 : 3;
   endfunction
   // At most one result bus owner in any cycle
   always @(negedge clock) begin
      if (nrst === 1'b1) check($onehot0(grant), "several grants at once");
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      // Op codes in the package enum order
      logic [3:0] ops [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h5, 4'h6, 4'h8, 4'h8,
         4'h9, 4'hF};
      logic [3:0] lops [10] = '{4'hA, 4'hA, 4'hB, 4'hB, 4'hC, 4'hD, 4'hD, 4'hD, 4'hE, 4'hA};
      logic [11:0] tks = 12'h1A0;
      logic [9:0]  ld1 = 10'h0C2;
      logic [9:0]  ld2 = 10'h080;
      logic [9:0]  lr0 = 10'h008;
      logic [9:0]  lu = 10'h200;
      wbarb_pkg::wba_issue_s iss;
      logic [4:0] r, q;
      int n, base;
      void'($urandom(25));
      repeat (8) @(posedge clock);
      check(grant === 5'h00 && sb === 32'h0 && ack === 1'b0, "outputs set in reset");
      #1 nrst = 1'b1;
      tick(1);
      // Spacing of accepts, each kind followed by a plain integer op
      for (int k = 0; k < 12; k++) begin
         issue = mk(ops[k], 5'h00, 5'h00, 5'h00, 1'b0, tks[k]);
         wait_on(-1, n);
         issue = mk(wbarb_pkg::WBA_OP_IU, 5'h00, 5'h00, 5'h00, 1'b0, 1'b0);
         wait_on(-1, n);
         check(n === exp_clks(ops[k], tks[k]), "issue spacing");
         issue.valid = 1'b0;
         tick(1);
      end
      $display("Spacing test done");
      // Reservation, hold, forwarding and the skipped source checks
      r = 5'h02 + 5'($urandom_range(0, 13));
      q = r + 5'h0E;
      issue = mk(wbarb_pkg::WBA_OP_IU, 5'h00, 5'h00, r, 1'b1, 1'b0);
      wait_on(-1, n);
      issue = mk(wbarb_pkg::WBA_OP_IU, r, 5'h00, q, 1'b1, 1'b0);
      tick(4);
      check(sb[r] === 1'b1, "destination not reserved");
      check(ack === 1'b0 && hold === 1'b1, "dependent issue not held");
      iu_wb = '{1'b1, r, $urandom()};
      tick(1);
      iu_wb.valid = 1'b0;
      check(ack === 1'b1 && frs1 === 1'b1 && frs2 === 1'b0, "not forwarded");
      issue = mk(wbarb_pkg::WBA_OP_FF1, 5'h00, q, 5'h00, 1'b1, 1'b0);
      wait_on(-1, n);
      check(n === 1, "find first held on second source");
      issue = mk(wbarb_pkg::WBA_OP_RDCR, q, q, 5'h00, 1'b1, 1'b0);
      wait_on(-1, n);
      check(n === 1, "control read held on sources");
      issue = mk(wbarb_pkg::WBA_OP_WRCR, 5'h00, q, q, 1'b1, 1'b0);
      wait_on(-1, n);
      check(n === 1, "control write held on destination");
      issue = mk(wbarb_pkg::WBA_OP_CALL, 5'h00, 5'h00, 5'h00, 1'b1, 1'b1);
      wait_on(-1, n);
      issue.valid = 1'b0;
      iu_wb = '{1'b1, q, $urandom()};
      tick(2);
      check(sb[1] === 1'b1, "link register not reserved");
      iu_wb = '{1'b1, 5'h01, $urandom()};
      tick(1);
      iu_wb.valid = 1'b0;
      tick(2);
      check(sb[1] === 1'b0 && sb[q] === 1'b0, "reservation not released");
      $display("Scoreboard test done");
      // Fetch wait replies hold the next instruction
      fetch_wait = 1'b1;
      tick($urandom_range(2, 6));
      check(hold === 1'b1, "fetch wait not held");
      fetch_wait = 1'b0;
      issue = mk(wbarb_pkg::WBA_OP_IU, 5'h00, 5'h00, 5'h00, 1'b0, 1'b0);
      wait_on(-1, n);
      check(n === 1 && hold === 1'b0, "no advance after success");
      issue.valid = 1'b0;
      // Load alone after random wait replies
      load(4'($urandom_range(0, 3)));
      wait_on(5, n);
      wait_on(4, n);
      check(n === 4 && rbus === {1'b1, ld_dest, ld_data}, "load writeback");
      $display("Wait and load test done");
      // Integer unit hogs the slot while multiply, add pipe and a load finish
      for (int k = 0; k < 2; k++) begin
         fpu_add_res = $urandom();
         fpu_mul_res = $urandom();
         iss = mk(k ? wbarb_pkg::WBA_OP_IMUL : wbarb_pkg::WBA_OP_FMUL, 5'h00, 5'h00, 5'h10,
            1'b0, 1'b0);
         issue = iss;
         wait_on(-1, n);
         issue = mk(wbarb_pkg::WBA_OP_FADD, 5'h00, 5'h00, 5'h12, 1'b0, 1'b0);
         wait_on(-1, n);
         issue.valid = 1'b0;
         iu_wb = '{1'b1, 5'h14, $urandom()};
         load(4'h0);
         tick(12);
         check(grant === 5'h01 && fas === 1'b1 && fms === 1'b1, "refused units");
         iu_wb.valid = 1'b0;
         wait_on(k ? 1 : 2, n);
         check(n === 1 && rbus.data === fpu_mul_res, "multiply not next");
         wait_on(3, n);
         check(n === 1 && rbus.data === fpu_add_res, "add pipe not next");
         wait_on(4, n);
         check(n === 1 && rbus.data === ld_data, "load not last");
         tick(2);
      end
      $display("Priority test done");
      // Unit latencies against a single-precision add as reference
      for (int k = 0; k < 10; k++) begin
         iss = mk(lops[k], 5'h00, 5'h00, {4'h8, lr0[k]}, 1'b0, 1'b0);
         iss.s1_dbl = ld1[k];
         iss.s2_dbl = ld2[k];
         iss.dbl_use = lu[k];
         issue = iss;
         wait_on(-1, n);
         issue.valid = 1'b0;
         wait_on(gbit(lops[k]), n);
         if (k == 0) base = n;
         check(n - base === exp_lat(lops[k], ld1[k], ld2[k], lr0[k], lu[k]) - 5, "latency");
         tick(2);
      end
      $display("Latency test done");
      test_done();
   end
endmodule
